/* aascr_regs.sv */
// Purpose: write-only command registers behind the three-wire control bus
// Assumes: bus lines synchronous to clock_i; bus far slower than 20 MHz
// Notes:   no timeout anywhere, so pauses of any length are tolerated
`timescale 1ns/1ns
`default_nettype none
module aascr_regs (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // control bus, receive only
    input  wire logic frame_select_line_i,  // select line, low during address
    input  wire logic bus_clock_line_i,     // bus clock, sample while high
    input  wire logic bus_data_i,           // data line
    // main clock
    input  wire logic main_clk_i,           // main clock level
    // modulator inputs (comparator decisions from analog side)
    input  wire logic mod_one_bit_i,
    input  wire logic mod_two_bit_i,
    // analog switch controls
    output logic      source_select_switch_o,
    output logic      dematrix_switch_o,
    output logic      output_route_switch_a_o,
    output logic      output_route_switch_b_o,
    output logic      output_route_switch_c_o,
    output logic      mute_o,
    output logic      dematrix_enable_o,
    output logic      aux_pin_o,
    output logic      div_three_o,
    // level control
    output logic      sense_one_o,
    output logic      sense_two_o,
    output logic      full_gain_o,
    output logic      discharge_o,
    // modulator streams
    output logic      modulator_one_stream_o,
    output logic      modulator_two_stream_o
);
    typedef enum logic [3:0] {
        AASCR_IDLE = 4'b0001,  // waiting for select low
        AASCR_ADDR = 4'b0010,  // shifting address bits
        AASCR_DATA = 4'b0100,  // shifting data bits
        AASCR_SKIP = 4'b1000   // not addressed, wait for end
    } aascr_state_t;

    aascr_state_t state, next_state;   // receiver state
    logic         sel_q, clk_q;        // previous line levels
    logic [7:0]   addr, next_addr;     // address shift register
    logic [3:0]   abits, next_abits;   // address bits taken
    logic [15:0]  data, next_data;     // data shift register
    logic [4:0]   dbits, next_dbits;   // data bits taken
    logic [7:0]   ctrl, next_ctrl;     // control word
    logic [7:0]   sense, next_sense;   // level-sense word
    logic         clk_rise;            // bus clock rising edge
    logic         sel_fall, sel_rise;  // select line edges
    logic [7:0]   rx_byte;             // first data byte received
    logic         div_sample;          // modulator sample strobe
    // next values of the output flip-flops
    logic         next_source_select_switch; // switch one
    logic         next_dematrix_switch;      // switch two
    logic         next_route_a;              // switch three
    logic         next_route_b;              // switch four
    logic         next_route_c;              // switch five
    logic         next_mute;                 // mute
    logic         next_dematrix_enable;      // dematrix on
    logic         next_aux_pin;              // static bit-6 pin
    logic         next_div_three;            // 3:1 ratio chosen
    logic         next_sense_one;            // channel one sensed
    logic         next_sense_two;            // channel two sensed
    logic         next_full_gain;            // level control at full gain
    logic         next_discharge;            // timing capacitor discharge
    logic         next_stream_one;           // first modulator stream
    logic         next_stream_two;           // second modulator stream
    logic         sense_none;                // no channel selected

    // edges of the bus lines
    assign clk_rise = bus_clock_line_i && !clk_q;
    assign sel_fall = !frame_select_line_i && sel_q;
    assign sel_rise = frame_select_line_i && !sel_q;

    // data arrive lsb first into the top; with 8 bits the byte sits high
    always_comb begin
        rx_byte = (dbits > 5'h08) ? data[7:0] : data[15:8];
    end

    // receiver next state; device never drives the data line [RULE1]
    always_comb begin
        next_state = state;
        next_addr  = addr;
        next_abits = abits;
        next_data  = data;
        next_dbits = dbits;
        next_ctrl  = ctrl;
        next_sense = sense;
        unique case (state)
            AASCR_IDLE: begin
                if (sel_fall) begin // [RULE12]
                    next_state = AASCR_ADDR;
                    next_abits = 4'h0;
                end
            end
            AASCR_ADDR: begin
                if (clk_rise && !frame_select_line_i) begin
                    next_addr  = {bus_data_i, addr[7:1]}; // [RULE12]
                    next_abits = abits + 4'h1;
                end
                if (sel_rise) begin // [RULE13]
                    next_dbits = 5'h00;
                    if (abits == 4'(aascr_pkg::ADDR_BITS) &&
                        (addr == aascr_pkg::ADDR_CONTROL ||
                         addr == aascr_pkg::ADDR_SENSE)) begin
                        next_state = AASCR_DATA;
                    end else begin
                        next_state = AASCR_SKIP; // [RULE16]
                    end
                end
            end
            AASCR_DATA: begin
                if (clk_rise && dbits < aascr_pkg::DATA_BITS_MAX) begin
                    next_data  = {bus_data_i, data[15:1]}; // [RULE13]
                    next_dbits = dbits + 5'h01;
                end
                // closing select pulse commits; no timeout [RULE14] [RULE15]
                if (sel_fall) begin
                    next_state = AASCR_IDLE;
                    if (dbits != 5'h00) begin
                        if (addr == aascr_pkg::ADDR_CONTROL) begin
                            next_ctrl = rx_byte; // [RULE2]
                        end else begin
                            next_sense = rx_byte; // [RULE6]
                        end
                    end
                end
            end
            AASCR_SKIP: begin
                if (sel_fall) begin
                    next_state = AASCR_IDLE; // [RULE16]
                end
            end
        endcase
    end

    // receiver registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= AASCR_IDLE;
            sel_q <= 1'b1;
            clk_q <= 1'b1;
            addr  <= 8'h00;
            abits <= 4'h0;
            data  <= 16'h0000;
            dbits <= 5'h00;
            ctrl  <= aascr_pkg::RESET_WORD;  // [RULE17]
            sense <= aascr_pkg::RESET_WORD;  // [RULE17]
        end else begin
            state <= next_state;
            sel_q <= frame_select_line_i;
            clk_q <= bus_clock_line_i;
            addr  <= next_addr;
            abits <= next_abits;
            data  <= next_data;
            dbits <= next_dbits;
            ctrl  <= next_ctrl;
            sense <= next_sense;
        end
    end

    // modulator sample clock from the divided main clock
    aascr_clock_divider aascr_clock_divider_inst (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .main_clk_i  (main_clk_i),
        .div_three_i (ctrl[aascr_pkg::BIT_DIV]),
        .sample_o    (div_sample)
    );

    // output next values; switch and sense flops copy one word bit, gain and discharge decode two, streams sample inputs
    always_comb begin
        next_route_c              = ctrl[aascr_pkg::BIT_SW5];  // [RULE11]
        next_route_b              = ctrl[aascr_pkg::BIT_SW4];  // [RULE11]
        next_route_a              = ctrl[aascr_pkg::BIT_SW3];  // [RULE11]
        next_mute                 = ctrl[aascr_pkg::BIT_MUTE]; // [RULE2]
        next_dematrix_switch      = ctrl[aascr_pkg::BIT_SW2];  // [RULE11]
        // same bit as switch two, so dematrix and switch cannot disagree
        next_dematrix_enable      = ctrl[aascr_pkg::BIT_SW2];  // [RULE5]
        next_source_select_switch = ctrl[aascr_pkg::BIT_SW1];  // [RULE11]
        next_aux_pin              = ctrl[aascr_pkg::BIT_PIN];  // [RULE3]
        next_div_three            = ctrl[aascr_pkg::BIT_DIV];  // [RULE4]
        next_sense_one            = sense[aascr_pkg::BIT_SENSE_ONE]; // [RULE8]
        next_sense_two            = sense[aascr_pkg::BIT_SENSE_TWO]; // [RULE8]
        // unused sense bits ignored, whatever the controller sent [RULE9]
        sense_none                = !(sense[aascr_pkg::BIT_SENSE_ONE] ||
                                      sense[aascr_pkg::BIT_SENSE_TWO]);
        // no channel sensed: full gain and fast discharge together
        next_full_gain            = sense_none; // [RULE7]
        next_discharge            = sense_none; // [RULE7]
        // streams hold between strobes, so the strobe alone sets their rate
        next_stream_one           = modulator_one_stream_o;
        next_stream_two           = modulator_two_stream_o;
        if (div_sample) begin
            next_stream_one = mod_one_bit_i; // [RULE10]
            next_stream_two = mod_two_bit_i; // [RULE10]
        end
    end

    // output registers, each a flip-flop
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            source_select_switch_o  <= 1'b0;
            dematrix_switch_o       <= 1'b0;
            output_route_switch_a_o <= 1'b0;
            output_route_switch_b_o <= 1'b0;
            output_route_switch_c_o <= 1'b0;
            mute_o                  <= 1'b0;
            dematrix_enable_o       <= 1'b0;
            aux_pin_o               <= 1'b0;
            div_three_o             <= 1'b0;
            sense_one_o             <= 1'b0;
            sense_two_o             <= 1'b0;
            full_gain_o             <= 1'b1;
            discharge_o             <= 1'b1;
            modulator_one_stream_o  <= 1'b0;
            modulator_two_stream_o  <= 1'b0;
        end else begin
            output_route_switch_c_o <= next_route_c;
            output_route_switch_b_o <= next_route_b;
            output_route_switch_a_o <= next_route_a;
            mute_o                  <= next_mute;
            dematrix_switch_o       <= next_dematrix_switch;
            dematrix_enable_o       <= next_dematrix_enable;
            source_select_switch_o  <= next_source_select_switch;
            aux_pin_o               <= next_aux_pin;
            div_three_o             <= next_div_three;
            sense_one_o             <= next_sense_one;
            sense_two_o             <= next_sense_two;
            full_gain_o             <= next_full_gain;
            discharge_o             <= next_discharge;
            modulator_one_stream_o  <= next_stream_one;
            modulator_two_stream_o  <= next_stream_two;
        end
    end

    // checks: each word bit reaches its pin one cycle after the word
    a_mute_follows: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE2]
        ##1 mute_o == $past(ctrl[aascr_pkg::BIT_MUTE]))
        else $error("mute out of step with control word");
    a_pin_follows: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE3]
        ##1 aux_pin_o == $past(ctrl[aascr_pkg::BIT_PIN]))
        else $error("aux pin out of step with bit 6");
    a_div_follows: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE4]
        ##1 div_three_o == $past(ctrl[aascr_pkg::BIT_DIV]))
        else $error("divider select wrong");
    a_dematrix_sw2: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE5]
        ##1 dematrix_enable_o == $past(ctrl[aascr_pkg::BIT_SW2]))
        else $error("dematrix not tied to switch two");
    a_switch_two: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE11]
        ##1 dematrix_switch_o == $past(ctrl[aascr_pkg::BIT_SW2]))
        else $error("switch two wrong");
    a_route_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE11]
        ##1 output_route_switch_a_o == $past(ctrl[aascr_pkg::BIT_SW3]))
        else $error("switch three wrong");
    a_route_b: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE11]
        ##1 output_route_switch_b_o == $past(ctrl[aascr_pkg::BIT_SW4]))
        else $error("switch four wrong");
    a_route_c: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE11]
        ##1 output_route_switch_c_o == $past(ctrl[aascr_pkg::BIT_SW5]))
        else $error("switch five wrong");
    a_source_sw: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE11]
        ##1 source_select_switch_o == $past(ctrl[aascr_pkg::BIT_SW1]))
        else $error("switch one wrong");
    // level sensing and the forced full-gain state
    a_sense_one: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE8]
        ##1 sense_one_o == $past(sense[aascr_pkg::BIT_SENSE_ONE]))
        else $error("channel one sense wrong");
    a_sense_two: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE8]
        ##1 sense_two_o == $past(sense[aascr_pkg::BIT_SENSE_TWO]))
        else $error("channel two sense wrong");
    a_full_gain: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE7]
        ##1 full_gain_o == !($past(sense[aascr_pkg::BIT_SENSE_ONE]) ||
                             $past(sense[aascr_pkg::BIT_SENSE_TWO])))
        else $error("full gain not forced when sensing off");
    a_discharge_off: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE7]
        ##1 discharge_o == !($past(sense[aascr_pkg::BIT_SENSE_ONE]) ||
                             $past(sense[aascr_pkg::BIT_SENSE_TWO])))
        else $error("discharge not forced when sensing off");
    // words move only on the closing pulse of an addressed transfer
    a_commit_only: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE14]
        !$stable(ctrl) |-> $past(sel_fall) && $past(state) == AASCR_DATA)
        else $error("control word changed outside commit");
    a_commit_sense: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE14]
        !$stable(sense) |-> $past(sel_fall) && $past(state) == AASCR_DATA)
        else $error("sense word changed outside commit");
    a_sense_keep: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE16]
        !$stable(sense) |-> $past(addr) == aascr_pkg::ADDR_SENSE)
        else $error("sense word changed for wrong address");
    a_skip_keeps: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE16]
        state == AASCR_SKIP |=> $stable(ctrl) && $stable(sense))
        else $error("word changed for a foreign address");
    // modulator pacing from the divided main clock
    a_stream_rate: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE10]
        div_sample |=> !div_sample ##1 !div_sample)
        else $error("modulator strobe too fast");
    a_stream_hold: assert property (@(posedge clock_i) disable iff (rst_i) // [RULE10]
        !div_sample |=> $stable(modulator_one_stream_o) && $stable(modulator_two_stream_o))
        else $error("stream changed between strobes");
endmodule
`default_nettype wire

/* aascr_pkg.sv */
// Purpose: constants for the serial control register block of the audio converter
// Assumes: bus lines are sampled synchronously on clock_i (20 MHz)
// Notes:   all offsets, bit positions and the command-word reset value live here
// Summary of operation
// RULE1 - device only receives; never drives data line
// RULE2 - address 96: switches five..one and mute bits
// RULE3 - bit 6 drives dedicated static output pin
// RULE4 - bit 7 picks main clock divide three/four
// RULE5 - dematrix active only while switch-two bit high
// RULE6 - address 101: bit 5 channel one, bit 6 channel two
// RULE7 - no sensing enabled forces full gain, discharge
// RULE8 - level sensed in selected channel or both
// RULE9 - controller writes zero to unused bits
// RULE10 - modulator stream rate from divided clock, bounded
// RULE11 - each routing switch set by own bit
// RULE12 - lines idle high; address lsb first, sample clock high
// RULE13 - select rises after address; 8 or 16 data bits
// RULE14 - commit data only on closing select pulse
// RULE15 - hold partial transfer across long pauses
// RULE16 - ignore other addresses; keep last committed value
// RULE17 - both command words zero after reset
package aascr_pkg;
    localparam logic [7:0] ADDR_CONTROL   = 8'h60; // control word address (96)
    localparam logic [7:0] ADDR_SENSE     = 8'h65; // level-sense select address (101)
    localparam logic [7:0] RESET_WORD     = 8'h00; // both words after reset
    localparam int         BIT_SW5        = 0;
    localparam int         BIT_SW4        = 1;
    localparam int         BIT_SW3        = 2;
    localparam int         BIT_MUTE       = 3;
    localparam int         BIT_SW2        = 4;
    localparam int         BIT_SW1        = 5;
    localparam int         BIT_PIN        = 6;
    localparam int         BIT_DIV        = 7;
    localparam int         BIT_SENSE_ONE  = 5;
    localparam int         BIT_SENSE_TWO  = 6;
    localparam int         ADDR_BITS      = 8;
    localparam logic [1:0] DIV_FOUR_LAST  = 2'h3; // terminal count for 4:1
    localparam logic [1:0] DIV_THREE_LAST = 2'h2; // terminal count for 3:1
    localparam logic [4:0] DATA_BITS_MAX  = 5'h10; // at most sixteen data bits
endpackage

/* aascr_clock_divider.sv */
// Purpose: divides the main clock by four or three for the modulators
// Assumes: main clock arrives as a level sampled on clock_i
// Notes:   output is a one-cycle sample strobe per divided period
`timescale 1ns/1ns
`default_nettype none
module aascr_clock_divider (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // control
    input  wire logic main_clk_i,    // main clock level
    input  wire logic div_three_i,   // high selects 3:1
    // result
    output logic      sample_o       // one-cycle strobe per divided period
);
    logic       main_q;        // previous main clock level
    logic [1:0] count;         // main clock rising edges seen
    logic [1:0] next_count;
    logic       next_sample;
    logic [1:0] last;          // terminal count for the selected ratio

    // next count; ratio change applies at once to the period in progress
    always_comb begin
        last        = div_three_i ? aascr_pkg::DIV_THREE_LAST : aascr_pkg::DIV_FOUR_LAST; // [RULE4]
        next_count  = count;
        next_sample = 1'b0;
        if (main_clk_i && !main_q) begin
            if (count >= last) begin
                next_count  = 2'h0;
                next_sample = 1'b1; // [RULE10]
            end else begin
                next_count = count + 2'h1;
            end
        end
    end

    // register stage
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            main_q   <= 1'b0;
            count    <= 2'h0;
            sample_o <= 1'b0;
        end else begin
            main_q   <= main_clk_i;
            count    <= next_count;
            sample_o <= next_sample;
        end
    end
endmodule
`default_nettype wire

/* aascr_bus_master.sv */
// Purpose: behavioural controller driving the three-wire command bus
// Assumes: each bus level is held HOLD cycles of clock_i, above the two needed
// Notes:   device only listens, so this model alone drives the data line
`timescale 1ns/1ns
`default_nettype none
module aascr_bus_master #(
    parameter int HOLD = 3          // clock_i cycles per bus level
) (
    // clock
    input  wire logic clock_i,
    // bus lines, idle high
    output logic      sel_o,
    output logic      clk_o,
    output logic      data_o        // sole driver of the data line
);
    // lines idle high from time zero
    initial begin
        sel_o  = 1'b1;
        clk_o  = 1'b1;
        data_o = 1'b1;
    end
    // hold the present level, then step just past the edge
    task automatic hold();
        repeat (HOLD) @(posedge clock_i);
        #1;
    endtask
    // clock low with new data, then clock high while the device samples
    task automatic put_bit(input logic b);
        clk_o  = 1'b0;
        data_o = b;
        hold();
        clk_o = 1'b1;
        hold();
    endtask
    // address lsb first, then data lsb first; a stall after the fourth data bit
    task automatic send(input logic [7:0] addr, input int nbits, input logic [15:0] word,
                        input int pause);
        sel_o = 1'b0;
        for (int i = 0; i < 8; i++) begin
            put_bit(addr[i]);
        end
        sel_o = 1'b1; // address over
        hold();
        for (int i = 0; i < nbits; i++) begin
            put_bit(word[i]);
            if (i == 3) begin
                repeat (pause) @(posedge clock_i); // stall mid-transfer
                #1;
            end
        end
        data_o = 1'b1; // released line back at its pull-up level
        hold();
    endtask
    // short select pulse that stores the word
    task automatic close_frame();
        sel_o = 1'b0;
        hold();
        sel_o = 1'b1;
        hold();
    endtask
endmodule
`default_nettype wire

/* aascr_regs_test.sv */
// Purpose: self-checking bench for the serial command registers
// Assumes: bus driven by the controller model; main clock at half clock_i
// Notes:   expectations come from written word bits and driven decisions only, never from outputs
`timescale 1ns/1ns
`default_nettype none
module aascr_regs_test;
    logic clock_i, rst_i, main_clk, mod_one, mod_two; // bench-driven inputs
    logic sel, bclk, bdata;                            // bus lines
    logic sw1, sw2, swa, swb, swc, mute, dem, aux, div3, s1, s2, fg, dis, st1, st2;
    int   failures = 0;                                // mismatches
    int   n_tests  = 0;                                // comparisons
    aascr_bus_master aascr_bus_master_inst (.clock_i(clock_i), .sel_o(sel), .clk_o(bclk),
        .data_o(bdata));
    aascr_regs aascr_regs_inst (.clock_i(clock_i), .rst_i(rst_i), .frame_select_line_i(sel),
        .bus_clock_line_i(bclk), .bus_data_i(bdata), .main_clk_i(main_clk),
        .mod_one_bit_i(mod_one), .mod_two_bit_i(mod_two), .source_select_switch_o(sw1),
        .dematrix_switch_o(sw2), .output_route_switch_a_o(swa), .output_route_switch_b_o(swb),
        .output_route_switch_c_o(swc), .mute_o(mute), .dematrix_enable_o(dem), .aux_pin_o(aux),
        .div_three_o(div3), .sense_one_o(s1), .sense_two_o(s2), .full_gain_o(fg),
        .discharge_o(dis), .modulator_one_stream_o(st1), .modulator_two_stream_o(st2));
    // 20 MHz system clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // main clock toggles just after each edge, so it is never sampled mid-change
    always @(posedge clock_i) begin
        main_clk <= #1 ~main_clk;
    end
    // verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // single-bit compare
    task automatic check(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s is %b", $time, what, got);
        end
    endtask
    // every output decoded from the control word
    task automatic check_ctrl(input logic [7:0] w);
        check(swc, w[0], "switch c");
        check(swb, w[1], "switch b");
        check(swa, w[2], "switch a");
        check(mute, w[3], "mute");
        check(sw2, w[4], "dematrix switch");
        check(dem, w[4], "dematrix enable");
        check(sw1, w[5], "source switch");
        check(aux, w[6], "aux pin");
        check(div3, w[7], "divide select");
    endtask
    // level-sense outputs from the select word
    task automatic check_sense(input logic [7:0] w);
        check(s1, w[5], "sense one");
        check(s2, w[6], "sense two");
        check(fg, ~(w[5] | w[6]), "full gain");
        check(dis, ~(w[5] | w[6]), "discharge");
    endtask
    // complete eight-bit write and settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        aascr_bus_master_inst.send(a, 8, {8'h00, d}, 0);
        aascr_bus_master_inst.close_frame();
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    // every control bit at both levels
    task automatic test_control();
        logic [7:0] pat [4] = '{8'ha5, 8'h5a, 8'h10, 8'h00};
        foreach (pat[i]) begin
            wr(aascr_pkg::ADDR_CONTROL, pat[i]);
            check_ctrl(pat[i]);
        end
    endtask
    // each sensing choice, unused bits written low
    task automatic test_sense();
        logic [7:0] pat [4] = '{8'h20, 8'h40, 8'h60, 8'h00};
        foreach (pat[i]) begin
            wr(aascr_pkg::ADDR_SENSE, pat[i]);
            check_sense(pat[i]);
        end
    endtask
    // near-miss addresses must leave both words alone
    task automatic test_ignore();
        wr(aascr_pkg::ADDR_CONTROL, 8'h3c);
        wr(aascr_pkg::ADDR_SENSE, 8'h40);
        wr(8'h61, 8'hff);
        wr(8'h64, 8'hff);
        check_ctrl(8'h3c);
        check_sense(8'h40);
    endtask
    // sixteen bits with a long stall: nothing moves before the closing pulse
    task automatic test_commit();
        aascr_bus_master_inst.send(aascr_pkg::ADDR_CONTROL, 16, 16'hff83, 2000);
        check_ctrl(8'h3c);
        aascr_bus_master_inst.close_frame();
        repeat (3) @(posedge clock_i);
        #1;
        check_ctrl(8'h83); // first byte kept
    endtask
    // modulator streams follow their decisions within a few divided periods
    task automatic test_streams(input logic a, input logic b);
        int i;
        mod_one = a;
        mod_two = b;
        i = 0;
        while (i < 40 && (st1 !== a || st2 !== b)) begin
            @(posedge clock_i);
            #1;
            i++;
        end
        check(st1, a, "stream one");
        check(st2, b, "stream two");
    endtask
    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst_i    = 1'b1;
        main_clk = 1'b0;
        mod_one  = 1'b0;
        mod_two  = 1'b0;
        repeat (5) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        check_ctrl(8'h00);
        check_sense(8'h00);
        test_control();
        test_sense();
        test_ignore();
        test_commit();
        test_streams(1'b1, 1'b0);
        test_streams(1'b0, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
